// >>> hdl/drx_ctl.sv
// dual receive port select, lock mode, lane mode and equalizer test registers
`timescale 1ns/100ps
`default_nettype none
`include "drx_regs.svh"
// Behaviour
// [RULE1] with lock mode clear, lock shows only while linked and video is not disabled.
// [RULE2] with lock mode set, lock shows whenever linked to a serializer.
// [RULE3] raw back channel set passes the local gpio zero level straight to the back channel.
// [RULE4] lane mode field picks auto, forced two-lane, forced primary or forced secondary lane.
// [RULE5] with the second port selected, writes reach the port 1 copy and shared registers.
// [RULE6] with the second port selected, reads return port 1 and shared registers.
// [RULE7] first port select resets to 1 and steers writes and reads to port 0.
// [RULE8] with both selects set, writes reach both ports and per-port reads return port 1.
// [RULE9] the equalizer test register is kept per port.
// [RULE10] equalizer restart bit high restarts adaptation on both ports.
// [RULE11] the restart bit never clears itself; software writes it high then low.
// [RULE12] the floor start only takes effect while the floor enable is set.
// [RULE13] floor active makes adaptation start from a preset floor rather than zero.
// [RULE14] video disabled flag is a status copy loaded from the remote serializer.
// [RULE15] software forces dual-lane reception through the lane mode field.
// [RULE16] reserved bits read zero and writes to them do nothing.
// [RULE17] a lane mode change takes effect at the next link acquisition.
module drx_ctl #(
  parameter logic [3:0] FLOOR_VALUE = 4'h6
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire drx_pkg::drx_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic link_up_pin,
  input wire logic video_disabled_load,
  input wire logic video_disabled_value,
  input wire logic local_secondary_gpio_zero,
  output logic rx_lock,
  output logic backchannel_raw,
  output logic backchannel_raw_enable,
  output drx_pkg::drx_lane_mode_t active_lane_mode,
  output logic [3:0] port0_eq_start,
  output logic [3:0] port1_eq_start,
  output logic port0_eq_restart,
  output logic port1_eq_restart
);
  import drx_pkg::*;

  logic [7:0] ctl_q;
  logic [7:0] eq0_q;
  logic [7:0] eq1_q;
  logic video_disabled_q;
  logic link_meta_q, link_sync_q;
  logic gpio_meta_q, gpio_sync_q;
  logic [7:0] rd_d;
  logic wr_ctl, wr_eq;
  logic restart_any;
  logic [3:0] eq0_start, eq1_start;
  logic eq0_rst, eq1_rst;

  // pins cross into clk_sys through two flops
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      link_meta_q <= 1'b0;
      link_sync_q <= 1'b0;
      gpio_meta_q <= 1'b0;
      gpio_sync_q <= 1'b0;
    end
    else
    begin
      link_meta_q <= link_up_pin;
      link_sync_q <= link_meta_q;
      gpio_meta_q <= local_secondary_gpio_zero;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  assign wr_ctl = req.wr && (req.addr == `DRX_ADDR_DUAL_RECEIVE_CONTROL);
  assign wr_eq = req.wr && (req.addr == `DRX_ADDR_EQ_TEST);

  // control register: reserved bits masked off, port 0 select resets high
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      ctl_q <= `DRX_CTL_RESET; // see [RULE7]
    else if (wr_ctl)
      ctl_q <= req.wdata & `DRX_CTL_WMASK; // see [RULE16]
  end

  // per-port equalizer copies; a write lands in every selected copy
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      eq0_q <= `DRX_EQ_RESET;
      eq1_q <= `DRX_EQ_RESET;
    end
    else if (wr_eq)
    begin
      if (ctl_q[`DRX_BIT_FIRST_PORT_SELECT]) // see [RULE7] [RULE8]
        eq0_q <= req.wdata & `DRX_EQ_WMASK;
      if (ctl_q[`DRX_BIT_SECOND_PORT_SELECT]) // see [RULE5] [RULE8] [RULE9]
        eq1_q <= req.wdata & `DRX_EQ_WMASK;
    end
  end

  // video disabled copy only changes on a forward channel load
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      video_disabled_q <= 1'b0;
    else if (video_disabled_load)
      video_disabled_q <= video_disabled_value; // see [RULE14]
  end

  // read mux; port 1 wins when both selected
  always_comb
  begin
    rd_d = 8'h00;
    if (req.addr == `DRX_ADDR_DUAL_RECEIVE_CONTROL)
      rd_d = ctl_q;
    else if (req.addr == `DRX_ADDR_EQ_TEST)
      rd_d = ctl_q[`DRX_BIT_SECOND_PORT_SELECT] ? eq1_q : eq0_q; // see [RULE6] [RULE8]
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      if (req.rd)
        rdata <= rd_d;
    end
  end

  // lock indication; lock mode decides whether video must be present
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rx_lock <= 1'b0;
    else if (ctl_q[`DRX_BIT_LOCK_MODE])
      rx_lock <= link_sync_q; // see [RULE2]
    else
      rx_lock <= link_sync_q && !video_disabled_q; // see [RULE1]
  end

  // raw back channel: synced gpio level, no filtering
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      backchannel_raw <= 1'b0;
      backchannel_raw_enable <= 1'b0;
    end
    else
    begin
      backchannel_raw_enable <= ctl_q[`DRX_BIT_RAW_BC]; // see [RULE3]
      backchannel_raw <= ctl_q[`DRX_BIT_RAW_BC] & gpio_sync_q; // see [RULE3]
    end
  end

  // lane mode follows the field on every cycle the link is down, so a live link never jumps mode
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      active_lane_mode <= DRX_LANE_AUTO;
    else if (!link_sync_q)
      active_lane_mode <= drx_lane_mode_t'(ctl_q[`DRX_LANE_MODE_HI:`DRX_LANE_MODE_LO]); // see [RULE4] [RULE17] [RULE15]
  end

  // restart from either copy reaches both ports; bit stays until software clears it
  assign restart_any = eq0_q[`DRX_BIT_EQ_RESTART] | eq1_q[`DRX_BIT_EQ_RESTART]; // see [RULE10] [RULE11]

  drx_eq_port #(.FLOOR_VALUE(FLOOR_VALUE)) u_eq0 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .eq_reg(eq0_q),
    .restart(restart_any),
    .start_level(eq0_start),
    .adapt_restart(eq0_rst)
  );

  drx_eq_port #(.FLOOR_VALUE(FLOOR_VALUE)) u_eq1 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .eq_reg(eq1_q),
    .restart(restart_any),
    .start_level(eq1_start),
    .adapt_restart(eq1_rst)
  );

  // registered copies for direct-from-flop outputs
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      port0_eq_start <= 4'h0;
      port1_eq_start <= 4'h0;
      port0_eq_restart <= 1'b0;
      port1_eq_restart <= 1'b0;
    end
    else
    begin
      port0_eq_start <= eq0_start;
      port1_eq_start <= eq1_start;
      port0_eq_restart <= eq0_rst;
      port1_eq_restart <= eq1_rst;
    end
  end

  property p_lock_video;
    @(posedge clk_sys) disable iff (!nrst)
      (!ctl_q[`DRX_BIT_LOCK_MODE] && video_disabled_q) |=> !rx_lock;
  endproperty
  a_lock_video: assert property (p_lock_video) else $error("lock with video disabled"); // see [RULE1]

  property p_lock_link;
    @(posedge clk_sys) disable iff (!nrst)
      (ctl_q[`DRX_BIT_LOCK_MODE] && link_sync_q) |=> rx_lock;
  endproperty
  a_lock_link: assert property (p_lock_link) else $error("no lock while linked"); // see [RULE2]

  property p_raw_bc;
    @(posedge clk_sys) disable iff (!nrst)
      ctl_q[`DRX_BIT_RAW_BC] |=> (backchannel_raw == $past(gpio_sync_q));
  endproperty
  a_raw_bc: assert property (p_raw_bc) else $error("raw back channel mismatch"); // see [RULE3]

  property p_wr_p1;
    @(posedge clk_sys) disable iff (!nrst)
      (wr_eq && ctl_q[`DRX_BIT_SECOND_PORT_SELECT]) |=> (eq1_q == ($past(req.wdata) & `DRX_EQ_WMASK));
  endproperty
  a_wr_p1: assert property (p_wr_p1) else $error("port 1 copy not written"); // see [RULE5]

  property p_rd_p1;
    @(posedge clk_sys) disable iff (!nrst)
      (req.rd && req.addr == `DRX_ADDR_EQ_TEST && ctl_q[`DRX_BIT_SECOND_PORT_SELECT] && !wr_eq)
      |=> (rdata == eq1_q);
  endproperty
  a_rd_p1: assert property (p_rd_p1) else $error("read not from port 1"); // see [RULE6] [RULE8]

  // every read strobe is answered exactly one cycle later
  property p_rvalid;
    @(posedge clk_sys) disable iff (!nrst)
      req.rd |=> rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered"); // see [RULE6]

  property p_wr_p0;
    @(posedge clk_sys) disable iff (!nrst)
      (wr_eq && ctl_q[`DRX_BIT_FIRST_PORT_SELECT]) |=> (eq0_q == ($past(req.wdata) & `DRX_EQ_WMASK));
  endproperty
  a_wr_p0: assert property (p_wr_p0) else $error("port 0 copy not written"); // see [RULE7]

  property p_restart_both;
    @(posedge clk_sys) disable iff (!nrst)
      restart_any |-> ##2 (port0_eq_restart && port1_eq_restart);
  endproperty
  a_restart_both: assert property (p_restart_both) else $error("restart missed a port"); // see [RULE10] [RULE11]

  property p_floor;
    @(posedge clk_sys) disable iff (!nrst)
      !eq0_q[`DRX_BIT_FLOOR_EN] |-> ##2 (port0_eq_start == 4'h0);
  endproperty
  a_floor: assert property (p_floor) else $error("floor used without enable"); // see [RULE12] [RULE13]

  property p_reserved;
    @(posedge clk_sys) disable iff (!nrst)
      ((ctl_q & ~`DRX_CTL_WMASK) == 8'h00) && ((eq1_q & ~`DRX_EQ_WMASK) == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // see [RULE16]

  property p_mode_hold;
    @(posedge clk_sys) disable iff (!nrst)
      (link_sync_q && $past(link_sync_q)) |-> $stable(active_lane_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("lane mode changed on live link"); // see [RULE17]

  c_both_sel: cover property (@(posedge clk_sys) disable iff (!nrst)
    wr_eq && ctl_q[1] && ctl_q[0]);
  c_lock: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(rx_lock));
  c_restart: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(restart_any));
endmodule // drx_ctl
`default_nettype wire

// >>> hdl/drx_eq_port.sv
// one receive port's equalizer start-level selection
`timescale 1ns/100ps
`default_nettype none
`include "drx_regs.svh"
module drx_eq_port #(
  parameter int FLOOR_W = 4,
  parameter logic [3:0] FLOOR_VALUE = 4'h6
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] eq_reg,
  input wire logic restart,
  output logic [3:0] start_level,
  output logic adapt_restart
);

  // floor only counts while the enable is set
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      start_level <= 4'h0;
    else if (eq_reg[`DRX_BIT_FLOOR_EN] && eq_reg[`DRX_BIT_FLOOR_START]) // see [RULE12] [RULE13]
      start_level <= FLOOR_VALUE;
    else
      start_level <= 4'h0;
  end

  // level restart: held while bit high, adaptation runs after low
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      adapt_restart <= 1'b0;
    else
      adapt_restart <= restart; // see [RULE10]
  end

  property p_restart_follow;
    @(posedge clk_sys) disable iff (!nrst) restart |=> adapt_restart;
  endproperty
  a_restart_follow: assert property (p_restart_follow) else $error("restart not applied"); // see [RULE10]
endmodule // drx_eq_port
`default_nettype wire

// >>> hdl/drx_pkg.sv
// types shared by the dual receive control bank
package drx_pkg;
  typedef enum logic [1:0] {
    DRX_LANE_AUTO = 2'h0,
    DRX_LANE_DUAL = 2'h1,
    DRX_LANE_PRI = 2'h2,
    DRX_LANE_SEC = 2'h3
  } drx_lane_mode_t;

  // register access from the serial target
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } drx_req_t;

  // per-port equalizer controls
  typedef struct packed {
    logic restart;
    logic floor_en;
    logic floor_start;
  } drx_eq_ctl_t;
endpackage

// >>> hdl/drx_regs.svh
// register offsets, field positions, reset values and timing counts of the dual receive control bank
`ifndef DRX_REGS_SVH
`define DRX_REGS_SVH
`define DRX_ADDR_DUAL_RECEIVE_CONTROL 8'h34
`define DRX_ADDR_EQ_TEST 8'h35
`define DRX_BIT_LOCK_MODE 6
`define DRX_BIT_RAW_BC 5
`define DRX_LANE_MODE_HI 4
`define DRX_LANE_MODE_LO 3
`define DRX_BIT_SECOND_PORT_SELECT 1
`define DRX_BIT_FIRST_PORT_SELECT 0
`define DRX_BIT_EQ_RESTART 6
`define DRX_BIT_FLOOR_EN 5
`define DRX_BIT_FLOOR_START 4
`define DRX_CTL_RESET 8'h01
`define DRX_CTL_WMASK 8'h7b
`define DRX_EQ_RESET 8'h00
`define DRX_EQ_WMASK 8'h70
`define DRX_ACQ_CYCLES 4
`endif

// >>> test/drx_link_model.sv
// far-side model: serializer link level, video-disabled status loads, gpio zero level
`timescale 1ns/100ps
`default_nettype none
module drx_link_model (
  input wire logic clk_sys,
  input wire logic linked,
  input wire logic vid_off,
  input wire logic gpio_lvl,
  output logic link_up_pin = 1'b0,
  output logic video_disabled_load = 1'b0,
  output logic video_disabled_value = 1'b0,
  output logic local_secondary_gpio_zero = 1'b0
);
  logic sent_q = 1'b0;
  // levels move only on clock edges, like a far end launching from its own flops
  always @(posedge clk_sys)
  begin
    link_up_pin <= linked;
    local_secondary_gpio_zero <= gpio_lvl;
  end
  // status copy is pushed as a one-cycle load only when the serializer flag changes
  always @(posedge clk_sys)
  begin
    video_disabled_load <= vid_off != sent_q;
    video_disabled_value <= vid_off;
    sent_q <= vid_off;
  end
endmodule // drx_link_model
`default_nettype wire

// >>> test/dual_rx_port_and_eq_control_test.sv
// self-checking bench for the dual receive control bank
`timescale 1ns/100ps
`default_nettype none
module dual_rx_port_and_eq_control_test;
  import drx_pkg::*;
  localparam logic [3:0] FLOOR = 4'h6;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  drx_req_t req = '0;
  logic linked = 1'b0;
  logic vid_off = 1'b0;
  logic gpio_lvl = 1'b0;
  logic [7:0] rdata;
  logic rvalid, rx_lock, bc_raw, bc_en, lu, vl, vv, gz;
  logic [3:0] st0, st1;
  logic rs0, rs1;
  drx_lane_mode_t lane;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  drx_link_model far (.clk_sys(clk_sys), .linked(linked), .vid_off(vid_off),
    .gpio_lvl(gpio_lvl), .link_up_pin(lu), .video_disabled_load(vl),
    .video_disabled_value(vv), .local_secondary_gpio_zero(gz));
  drx_ctl #(.FLOOR_VALUE(FLOOR)) DUT (.clk_sys(clk_sys), .nrst(nrst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .link_up_pin(lu), .video_disabled_load(vl),
    .video_disabled_value(vv), .local_secondary_gpio_zero(gz), .rx_lock(rx_lock),
    .backchannel_raw(bc_raw), .backchannel_raw_enable(bc_en), .active_lane_mode(lane),
    .port0_eq_start(st0), .port1_eq_start(st1), .port0_eq_restart(rs0),
    .port1_eq_restart(rs1));
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard well above the roughly 160 cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  // read strobe, then wait a bounded time for the registered answer
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  initial
  begin
    tick(4);
    nrst <= 1'b1;
    rd_chk(8'h34, 8'h01);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h36, 8'h00);
    wr(8'h34, 8'hff);
    rd_chk(8'h34, 8'h7b);
    $display("test reset done");
    // both selects: write lands in both copies, restart from port 1 copy reaches port 0
    wr(8'h35, 8'hff);
    rd_chk(8'h35, 8'h70);
    wr(8'h34, 8'h01);
    rd_chk(8'h35, 8'h70);
    wr(8'h35, 8'h00);
    wr(8'h34, 8'h02);
    rd_chk(8'h35, 8'h70);
    tick(4);
    chk({4'h0, st1}, {4'h0, FLOOR});
    chk({4'h0, st0}, 8'h00);
    chk({7'h0, rs0}, 8'h01);
    wr(8'h35, 8'h10);
    tick(4);
    chk({4'h0, st1}, 8'h00);
    chk({7'h0, rs1}, 8'h00);
    wr(8'h34, 8'h01);
    rd_chk(8'h35, 8'h00);
    $display("test ports done");
    wr(8'h35, 8'h40);
    tick(4);
    chk({6'h0, rs0, rs1}, 8'h03);
    tick(20);
    chk({6'h0, rs0, rs1}, 8'h03);
    wr(8'h35, 8'h00);
    tick(4);
    chk({6'h0, rs0, rs1}, 8'h00);
    $display("test restart done");
    // lane mode latched only while the link is down
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h34, {3'h0, m[1:0], 3'h1});
      tick(4);
      chk({6'h0, lane}, {6'h0, m[1:0]});
    end
    @(posedge clk_sys);
    linked <= 1'b1;
    tick(6);
    wr(8'h34, 8'h09);
    tick(4);
    chk({6'h0, lane}, 8'h03);
    @(posedge clk_sys);
    linked <= 1'b0;
    tick(6);
    chk({6'h0, lane}, 8'h01);
    $display("test lane done");
    @(posedge clk_sys);
    vid_off <= 1'b1;
    linked <= 1'b1;
    wr(8'h34, 8'h01);
    tick(6);
    chk({7'h0, rx_lock}, 8'h00);
    vid_off <= 1'b0;
    tick(6);
    chk({7'h0, rx_lock}, 8'h01);
    vid_off <= 1'b1;
    wr(8'h34, 8'h41);
    tick(6);
    chk({7'h0, rx_lock}, 8'h01);
    linked <= 1'b0;
    tick(6);
    chk({7'h0, rx_lock}, 8'h00);
    $display("test lock done");
    wr(8'h34, 8'h21);
    gpio_lvl <= 1'b1;
    tick(6);
    chk({6'h0, bc_en, bc_raw}, 8'h03);
    gpio_lvl <= 1'b0;
    tick(6);
    chk({6'h0, bc_en, bc_raw}, 8'h02);
    $display("test raw done");
    conclude();
  end
endmodule // dual_rx_port_and_eq_control_test
`default_nettype wire
